// >>> rtl/dolc_gain_select.sv
// gain scheduling: pre or post sync selection of the loop gains
`include "dolc_regs.svh"
module dolc_gain_select
(
   // configuration
   input wire logic [7:0] foc_cfg,
   input wire logic [7:0] bsc_cfg,
   // state
   input wire logic post_sync,
   input wire logic frozen,
   // result
   output dolc_pkg::dolc_loop_ctrl_type ctrl
);
   function automatic logic [3:0] mult_half(input logic [1:0] f);
      mult_half = {1'b0, f + 2'h1, 1'b0};
      if (f == 2'h3)
         mult_half = 4'h8;
   endfunction

   logic [3:0] freq_pre;
   logic [3:0] ki_pre;
   logic [3:0] kp_pre;

   assign freq_pre = mult_half(foc_cfg[`DOLC_FOC_PRE_LSB +: 2]);
   assign ki_pre = mult_half(bsc_cfg[`DOLC_BSC_KI_LSB +: 2]);
   assign kp_pre = mult_half(bsc_cfg[`DOLC_BSC_KP_LSB +: 2]);

   always_comb
   begin
      ctrl = '0;
      ctrl.freeze = frozen;
      ctrl.freq_gain = (post_sync && foc_cfg[`DOLC_FOC_POST_BIT]) ? 4'h1 : freq_pre;
      ctrl.integral_gain = (post_sync && bsc_cfg[`DOLC_BSC_POSTKI_BIT]) ? 4'h1 : ki_pre;
      ctrl.proportional_gain = (post_sync && bsc_cfg[`DOLC_BSC_POSTKP_BIT]) ? 4'h2 : kp_pre;
      ctrl.freq_limit = foc_cfg[`DOLC_FOC_LIM_LSB +: 2];
      ctrl.rate_limit = bsc_cfg[`DOLC_BSC_LIM_LSB +: 2];
   end
endmodule

// >>> rtl/dolc_pkg.sv
// types of the offset loop configuration block
package dolc_pkg;
   // gains in half units of the base gain: 1 = K/2, 2 = K, 8 = 4K
   typedef struct packed {
      logic freeze;
      logic [3:0] freq_gain;
      logic [1:0] freq_limit;
      logic [3:0] integral_gain;
      logic [3:0] proportional_gain;
      logic [1:0] rate_limit;
   } dolc_loop_ctrl_type;
   typedef enum logic {DOLC_PRESYNC, DOLC_POSTSYNC} dolc_phase_type;
endpackage

// >>> rtl/dolc_regs.svh
// register offsets, field positions and reset values of the offset loop configuration
`ifndef DOLC_REGS_SVH
`define DOLC_REGS_SVH
`define DOLC_FOC_IDX 8'h19
`define DOLC_BSC_IDX 8'h1a
`define DOLC_FOC_ADDR 12'h064
`define DOLC_BSC_ADDR 12'h068
`define DOLC_FOC_RESET 8'h36
`define DOLC_BSC_RESET 8'h6c
`define DOLC_FOC_WMASK 8'h3f
`define DOLC_FOC_GATE_BIT 5
`define DOLC_FOC_PRE_LSB 3
`define DOLC_FOC_POST_BIT 2
`define DOLC_FOC_LIM_LSB 0
`define DOLC_BSC_KI_LSB 6
`define DOLC_BSC_KP_LSB 4
`define DOLC_BSC_POSTKI_BIT 3
`define DOLC_BSC_POSTKP_BIT 2
`define DOLC_BSC_LIM_LSB 0
`endif

// >>> rtl/dolc_top.sv
// offset loop configuration registers with apb slave and gain scheduling
//
// Register access over APB was left to the implementer.
`include "dolc_regs.svh"
module dolc_top
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // demodulator events, same clock
   input wire logic carrier_sense,
   input wire logic sync_detect,
   input wire logic search_start,
   // loop controls
   output dolc_pkg::dolc_loop_ctrl_type loop_ctrl,
   output logic [7:0] freq_offset_saturation,
   output logic [7:0] rate_offset_saturation
);
   logic [7:0] foc_q;
   logic [7:0] bsc_q;
   dolc_pkg::dolc_phase_type phase_q;
   logic sensed_q;
   logic [7:0] fsat_q;
   logic [7:0] rsat_q;
   logic wr_en;
   logic rd_en;
   logic hit_foc;
   logic hit_bsc;
   logic frozen;
   logic post_sync;

   assign hit_foc = paddr == `DOLC_FOC_ADDR;
   assign hit_bsc = paddr == `DOLC_BSC_ADDR;
   assign wr_en = psel && penable && pwrite;
   // read data loads at the setup edge so it stands through the access phase
   assign rd_en = psel && !penable && !pwrite;
   // zero wait states; unmapped addresses raise pslverr
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit_foc && !hit_bsc;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         foc_q <= `DOLC_FOC_RESET;
      else if (wr_en && hit_foc)
         foc_q <= pwdata[7:0] & `DOLC_FOC_WMASK;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bsc_q <= `DOLC_BSC_RESET;
      else if (wr_en && hit_bsc)
         bsc_q <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_en && hit_foc)
         prdata <= {24'h00_0000, foc_q};
      else if (rd_en && hit_bsc)
         prdata <= {24'h00_0000, bsc_q};
      else
         prdata <= 32'h0000_0000;
   end

   // sync detect wins over a simultaneous search start so no packet is missed
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         phase_q <= dolc_pkg::DOLC_PRESYNC;
      else
      begin
         case (phase_q)
            dolc_pkg::DOLC_PRESYNC:
               if (sync_detect)
                  phase_q <= dolc_pkg::DOLC_POSTSYNC;
            dolc_pkg::DOLC_POSTSYNC:
               if (search_start && !sync_detect)
                  phase_q <= dolc_pkg::DOLC_PRESYNC;
            default:
               phase_q <= dolc_pkg::DOLC_PRESYNC;
         endcase
      end
   end

   assign post_sync = sync_detect || (phase_q == dolc_pkg::DOLC_POSTSYNC && !search_start);

   // latch carrier sense per packet search; a search restart clears it unless carrier sense is high in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sensed_q <= 1'b0;
      else if (carrier_sense)
         sensed_q <= 1'b1;
      else if (search_start)
         sensed_q <= 1'b0;
   end

   assign frozen = foc_q[`DOLC_FOC_GATE_BIT] && !carrier_sense && !sensed_q;

   dolc_gain_select u_gain
   (
      .foc_cfg(foc_q),
      .bsc_cfg(bsc_q),
      .post_sync(post_sync),
      .frozen(frozen),
      .ctrl(loop_ctrl)
   );

   // limits as fractions in 1/256: bandwidth /8,/4,/2 and rate 3.125,6.25,12.5 percent
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fsat_q <= 8'h00;
         rsat_q <= 8'h00;
      end
      else
      begin
         case (foc_q[`DOLC_FOC_LIM_LSB +: 2])
            2'h1: fsat_q <= 8'h20;
            2'h2: fsat_q <= 8'h40;
            2'h3: fsat_q <= 8'h80;
            default: fsat_q <= 8'h00;
         endcase
         case (bsc_q[`DOLC_BSC_LIM_LSB +: 2])
            2'h1: rsat_q <= 8'h08;
            2'h2: rsat_q <= 8'h10;
            2'h3: rsat_q <= 8'h20;
            default: rsat_q <= 8'h00;
         endcase
      end
   end
   assign freq_offset_saturation = fsat_q;
   assign rate_offset_saturation = rsat_q;

   gate_freeze_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (foc_q[5] && !carrier_sense && !sensed_q) |-> loop_ctrl.freeze)
      else $error("loops not frozen while gated");
   gate_release_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (presetn && carrier_sense) |=> !loop_ctrl.freeze)
      else $error("loops frozen after carrier sense");
   freq_pre_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         !post_sync |-> loop_ctrl.freq_gain == {foc_q[4:3], 1'b0} + 4'h2)
      else $error("pre-sync frequency gain wrong");
   freq_post_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (sync_detect && foc_q[2]) |-> loop_ctrl.freq_gain == 4'h1)
      else $error("post-sync frequency gain wrong");
   fsat_value_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         ##1 (foc_q[1:0] == 2'h0 && $stable(foc_q)) |=> fsat_q == 8'h00)
      else $error("frequency saturation not off");
   ki_pre_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         !post_sync |-> loop_ctrl.integral_gain == {bsc_q[7:6], 1'b0} + 4'h2)
      else $error("pre-sync integral gain wrong");
   kp_pre_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         !post_sync |-> loop_ctrl.proportional_gain == {bsc_q[5:4], 1'b0} + 4'h2)
      else $error("pre-sync proportional gain wrong");
   ki_post_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (post_sync && bsc_q[3]) |-> loop_ctrl.integral_gain == 4'h1)
      else $error("post-sync integral gain wrong");
   kp_post_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (post_sync && bsc_q[2]) |-> loop_ctrl.proportional_gain == 4'h2)
      else $error("post-sync proportional gain wrong");
   rsat_value_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (bsc_q[1:0] == 2'h3) ##1 $stable(bsc_q) |=> rsat_q == 8'h20)
      else $error("rate saturation wrong");
   phase_hold_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (presetn && sync_detect) ##1 !search_start [*2] |-> post_sync)
      else $error("post-sync phase lost");

   pready_high_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (psel && penable)
         |-> pready)
      else $error("access phase without ready");

   slverr_map_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (psel && penable)
         |-> pslverr == (paddr != `DOLC_FOC_ADDR && paddr != `DOLC_BSC_ADDR))
      else $error("error response does not follow the address map");

   slverr_idle_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         !(psel && penable)
         |-> !pslverr)
      else $error("error response outside an access phase");

   foc_write_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (psel && penable && pwrite && paddr == `DOLC_FOC_ADDR)
         |=> {24'h00_0000, foc_q} == ($past(pwdata) & 32'h0000_003f))
      else $error("frequency config write lost");

   bsc_write_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (psel && penable && pwrite && paddr == `DOLC_BSC_ADDR)
         |=> {24'h00_0000, bsc_q} == ($past(pwdata) & 32'h0000_00ff))
      else $error("bit sync config write lost");

   foc_hold_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (presetn && !(psel && penable && pwrite && paddr == `DOLC_FOC_ADDR))
         |=> $stable(foc_q))
      else $error("frequency config changed without a write");

   bsc_hold_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (presetn && !(psel && penable && pwrite && paddr == `DOLC_BSC_ADDR))
         |=> $stable(bsc_q))
      else $error("bit sync config changed without a write");

   foc_unused_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         presetn
         |-> foc_q[7:6] == 2'h0)
      else $error("unused frequency config bits set");

   rdata_foc_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (presetn && psel && !penable && !pwrite && paddr == `DOLC_FOC_ADDR)
         |=> prdata == {24'h00_0000, foc_q})
      else $error("frequency config read data wrong");

   rdata_bsc_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (presetn && psel && !penable && !pwrite && paddr == `DOLC_BSC_ADDR)
         |=> prdata == {24'h00_0000, bsc_q})
      else $error("bit sync config read data wrong");

   rdata_stand_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (psel && penable && !pwrite && paddr == `DOLC_BSC_ADDR)
         |-> prdata == {24'h00_0000, bsc_q})
      else $error("read data not standing in the access phase");

   rdata_idle_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (presetn && !(psel && !penable && !pwrite))
         |=> prdata == 32'h0000_0000)
      else $error("read data not cleared");

   phase_enter_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (presetn && sync_detect)
         |=> phase_q == dolc_pkg::DOLC_POSTSYNC)
      else $error("post-sync phase not entered");

   phase_leave_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (presetn && search_start && !sync_detect)
         |=> phase_q == dolc_pkg::DOLC_PRESYNC)
      else $error("pre-sync phase not restored");

   phase_keep_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (presetn && !sync_detect && !search_start)
         |=> $stable(phase_q))
      else $error("phase changed without an event");

   post_search_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (search_start && !sync_detect)
         |-> !post_sync)
      else $error("post-sync gains during a new search");

   post_detect_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         sync_detect
         |-> post_sync)
      else $error("pre-sync gains in the detect cycle");

   sense_set_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (presetn && carrier_sense)
         |=> sensed_q)
      else $error("carrier sense not latched");

   sense_clear_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (presetn && search_start && !carrier_sense)
         |=> !sensed_q)
      else $error("carrier sense latch not cleared");

   gate_open_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         !foc_q[5]
         |-> !loop_ctrl.freeze)
      else $error("loops frozen with the gate clear");

   freeze_sensed_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (sensed_q || carrier_sense)
         |-> !loop_ctrl.freeze)
      else $error("loops frozen after carrier sense");

   freq_keep_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (post_sync && !foc_q[2])
         |-> loop_ctrl.freq_gain == {foc_q[4:3], 1'b0} + 4'h2)
      else $error("post-sync frequency gain not kept");

   ki_keep_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (post_sync && !bsc_q[3])
         |-> loop_ctrl.integral_gain == {bsc_q[7:6], 1'b0} + 4'h2)
      else $error("post-sync integral gain not kept");

   kp_keep_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (post_sync && !bsc_q[2])
         |-> loop_ctrl.proportional_gain == {bsc_q[5:4], 1'b0} + 4'h2)
      else $error("post-sync proportional gain not kept");

   fsat_eighth_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (presetn && foc_q[1:0] == 2'h1)
         |=> fsat_q == 8'h20)
      else $error("frequency saturation not one eighth");

   fsat_half_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (presetn && foc_q[1:0] == 2'h3)
         |=> fsat_q == 8'h80)
      else $error("frequency saturation not one half");

   rsat_low_a:
      assert property (@(posedge pclk) disable iff (!presetn)
         (presetn && bsc_q[1:0] == 2'h1)
         |=> rsat_q == 8'h08)
      else $error("rate saturation not lowest step");
endmodule

// >>> verification/dolc_top_tb.sv
// self-checking bench of the offset loop configuration block
`include "dolc_regs.svh"
module dolc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic carrier_sense = 0;
   logic sync_detect = 0;
   logic search_start = 0;
   dolc_pkg::dolc_loop_ctrl_type loop_ctrl;
   logic [7:0] freq_offset_saturation;
   logic [7:0] rate_offset_saturation;
   int fail_count = 0;
   int cmp_count = 0;
   int seed = 32'h90ae6327;
   logic [7:0] foc_m, bsc_m, fsat_m, rsat_m;
   logic post_m, cs_m, er;
   logic [15:0] gains_e;
   logic [31:0] rd;
   always #50 pclk = ~pclk;
   dolc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .carrier_sense(carrier_sense), .sync_detect(sync_detect),
      .search_start(search_start), .loop_ctrl(loop_ctrl),
      .freq_offset_saturation(freq_offset_saturation),
      .rate_offset_saturation(rate_offset_saturation));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // only the watchdog ends a wait for ready
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      // response and read data are taken at the accepting edge
      e = pslverr;
      r = prdata;
      psel <= 0;
      penable <= 0;
   endtask
   // gains in half units of the base gain
   function automatic logic [15:0] exp_ctrl(logic [7:0] f, logic [7:0] b, logic p);
      logic [3:0] fg, ig, pg;
      fg = (p && f[2]) ? 4'h1 : {1'b0, f[4:3], 1'b0} + 4'h2;
      ig = (p && b[3]) ? 4'h1 : {1'b0, b[7:6], 1'b0} + 4'h2;
      pg = (p && b[2]) ? 4'h2 : {1'b0, b[5:4], 1'b0} + 4'h2;
      return {fg, f[1:0], ig, pg, b[1:0]};
   endfunction
   assign gains_e = exp_ctrl(foc_m, bsc_m, sync_detect | (post_m & ~search_start));
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         foc_m <= 8'h36;
         bsc_m <= 8'h6c;
         fsat_m <= 8'h00;
         rsat_m <= 8'h00;
         post_m <= 0;
         cs_m <= 0;
      end
      else
      begin
         if (psel && penable && pwrite && paddr == `DOLC_FOC_ADDR)
            foc_m <= pwdata[7:0] & 8'h3f;
         if (psel && penable && pwrite && paddr == `DOLC_BSC_ADDR)
            bsc_m <= pwdata[7:0];
         fsat_m <= (foc_m[1:0] == 0) ? 8'h00 : 8'h10 << foc_m[1:0];
         rsat_m <= (bsc_m[1:0] == 0) ? 8'h00 : 8'h04 << bsc_m[1:0];
         post_m <= sync_detect | (post_m & ~search_start);
         cs_m <= carrier_sense | (cs_m & ~search_start);
      end
   // carrier sense never rises with a new search, so latch order cannot matter
   always @(posedge pclk)
   begin : demod
      logic [31:0] r;
      r = $random(seed);
      sync_detect <= r[2:0] == 0;
      search_start <= r[6:3] == 0;
      carrier_sense <= (r[6:3] != 0) && (carrier_sense ^ (r[11:8] == 0));
   end
   always @(negedge pclk)
      if (presetn)
      begin
         check(loop_ctrl[15:0], gains_e);
         check(loop_ctrl.freeze, foc_m[5] & ~carrier_sense & ~cs_m);
         check(freq_offset_saturation, fsat_m);
         check(rate_offset_saturation, rsat_m);
      end
   initial
   begin
      #1000000;
      fail_count++;
      finish_test();
   end
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      for (int i = 0; i < 120; i++)
      begin
         if (i == 60)
         begin
            presetn <= 0;
            @(posedge pclk);
            presetn <= 1;
         end
         apb(0, `DOLC_FOC_ADDR, 0, rd, er);
         check(rd, {24'h0, foc_m});
         apb(0, `DOLC_BSC_ADDR, 0, rd, er);
         check(rd, {24'h0, bsc_m});
         check(er, 0);
         apb(1, i[0] ? 12'h06c : 12'h060, $random(seed), rd, er);
         check(er, 1);
         apb(0, i[0] ? 12'h06c : 12'h060, 0, rd, er);
         check({er, rd[30:0]}, 32'h80000000);
         // random limits include zero, as the host uses for amplitude keying
         apb(1, `DOLC_FOC_ADDR, $random(seed), rd, er);
         apb(1, `DOLC_BSC_ADDR, $random(seed), rd, er);
      end
      finish_test();
   end
endmodule
